/* File: hw/emi_pkg.sv */
/*
  emi_pkg: constants, state encoding and carrier structs for the external
  data memory interface.
  Assumes a single 20 MHz system clock and an 8-bit register port.
*/
package emi_pkg;

  // ****************************************
  // register map on the plain register port
  // ****************************************
  localparam logic [1:0] OFF_CONFIG = 2'h0;
  localparam logic [1:0] OFF_PAGE = 2'h1;
  localparam logic [1:0] OFF_TIMING = 2'h2;
  localparam logic [1:0] OFF_STATUS = 2'h3;

  localparam logic [7:0] RST_CONFIG = 8'h03;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'hff;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CFG_MUX_SEL = 4;
  localparam int CFG_MODE_HI = 3;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_ALE_HI = 1;
  localparam int CFG_ALE_LO = 0;
  localparam int TMG_SETUP_HI = 7;
  localparam int TMG_SETUP_LO = 6;
  localparam int TMG_STROBE_HI = 5;
  localparam int TMG_STROBE_LO = 2;
  localparam int TMG_HOLD_HI = 1;
  localparam int TMG_HOLD_LO = 0;
  localparam logic [7:0] CFG_RW_MASK = 8'h1f;

  // ****************************************
  // memory modes and sizes
  // ****************************************
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
  localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;

  localparam int RAM_AW = 12;
  localparam logic [16:0] RAM_BYTES = 17'h01000;
  localparam logic [3:0] PREP_CYCLES = 4'h2;
  localparam logic [3:0] TAIL_CYCLES = 4'h2;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ONCHIP,
    ST_PREP,
    ST_ALE_HI,
    ST_ALE_LO,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_TAIL
  } emi_state_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic write;
    logic wide;
    logic [15:0] data_pointer;
    logic [7:0] index;
    logic [7:0] wdata;
  } emi_req_t;

  typedef struct packed {
    logic [7:0] addr_hi;
    logic addr_hi_oe_n;
    logic [7:0] addr_lo;
    logic addr_lo_oe_n;
    logic [7:0] ad_out;
    logic ad_oe_n;
    logic ale;
    logic rd_n;
    logic wr_n;
  } emi_pins_t;

endpackage : emi_pkg

/* File: hw/emi_ctrl.sv */
/*
  emi_ctrl: routes cpu external moves to on-chip data ram or to an off-chip
  asynchronous memory bus, multiplexed or not, with programmable timing.
  Assumes one synchronous clock, a cpu that holds off new moves while busy is
  high, and an external address latch when the multiplexed pins are used.
*/
`timescale 1ns/1ps

// Function
// - mode 00 sends moves on-chip only
// - internal mode wraps address at ram size
// - 8-bit address is page then index
// - 16-bit address comes from data pointer
// - split modes: below boundary on-chip, above off-chip
// - split no-bank: upper pins undriven, index low
// - split bank: page high byte, index low
// - split 16-bit: pointer decides, all pins driven
// - mode 11 sends all moves off-chip
// - external 8-bit: page ignored, upper undriven
// - external 16-bit drives all sixteen pins
// - latch width code gives 1 to 4 cycles
// - latch width used only when multiplexed
// - config bit 4 picks multiplexed pin sharing
// - latch high with address, then data phase
// - non-multiplexed uses separate address, data pins
// - timing programmable in whole clock periods
// - off-chip move is 4 plus programmed cycles
// - multiplexed adds two latch phases of code plus one cycles, minimum 7
// - setup and hold reset to maximum
// - mux bit cleared means multiplexed
// - setup code adds 0 to 3 cycles
// - strobe lasts code plus one cycles
// - hold code adds 0 to 3 cycles
module emi_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic req_valid,
  input wire emi_pkg::emi_req_t req,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output emi_pkg::emi_pins_t pins,
  input wire logic [7:0] ad_in
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    emi_pkg::emi_state_t state;
    logic [3:0] cnt;
    logic write;
    logic mux;
    logic hi_drv;
    logic offchip;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [emi_pkg::RAM_AW-1:0] ram_addr;
    logic [7:0] cfg;
    logic [7:0] page;
    logic [7:0] tmg;
    logic [7:0] reg_rdata;
    logic busy;
    logic done;
    logic [7:0] rdata;
    emi_pkg::emi_pins_t pins;
  } emi_regs_t;

  emi_regs_t s;
  emi_regs_t next_s;

  // on-chip data ram, kept outside the state record for size
  logic [7:0] ram [0:(1 << emi_pkg::RAM_AW)-1];

  logic [1:0] mode;
  logic [1:0] ale_code;
  logic [1:0] setup_code;
  logic [3:0] strobe_code;
  logic [1:0] hold_code;
  logic [15:0] eff_addr;
  logic below_boundary;
  logic go_onchip;
  logic drive_hi;
  logic in_bus;

  assign mode = s.cfg[emi_pkg::CFG_MODE_HI:emi_pkg::CFG_MODE_LO];
  assign ale_code = s.cfg[emi_pkg::CFG_ALE_HI:emi_pkg::CFG_ALE_LO];
  assign setup_code = s.tmg[emi_pkg::TMG_SETUP_HI:emi_pkg::TMG_SETUP_LO];
  assign strobe_code = s.tmg[emi_pkg::TMG_STROBE_HI:emi_pkg::TMG_STROBE_LO];
  assign hold_code = s.tmg[emi_pkg::TMG_HOLD_HI:emi_pkg::TMG_HOLD_LO];

  // ****************************************
  // address routing
  // ****************************************
  always_comb
  begin
    // 16-bit moves use the pointer, 8-bit ones page and index
    eff_addr = req.wide ? req.data_pointer : {s.page, req.index};
    below_boundary = ({1'b0, eff_addr} < emi_pkg::RAM_BYTES);
    unique case (mode)
      emi_pkg::MODE_INTERNAL:
      begin
        go_onchip = 1'b1;
      end
      emi_pkg::MODE_SPLIT_NOBANK,
      emi_pkg::MODE_SPLIT_BANK:
      begin
        go_onchip = below_boundary;
      end
      emi_pkg::MODE_EXTERNAL:
      begin
        go_onchip = 1'b0;
      end
    endcase
    // upper pins stay released for 8-bit moves unless bank select is on
    drive_hi = req.wide || (mode == emi_pkg::MODE_SPLIT_BANK);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;

    // register port
    if (reg_wr)
    begin
      unique case (reg_addr)
        emi_pkg::OFF_CONFIG:
        begin
          next_s.cfg = reg_wdata & emi_pkg::CFG_RW_MASK;
        end
        emi_pkg::OFF_PAGE:
        begin
          next_s.page = reg_wdata;
        end
        emi_pkg::OFF_TIMING:
        begin
          next_s.tmg = reg_wdata;
        end
        emi_pkg::OFF_STATUS:
        begin
          next_s.tmg = s.tmg;
        end
      endcase
    end
    next_s.reg_rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        emi_pkg::OFF_CONFIG:
        begin
          next_s.reg_rdata = s.cfg;
        end
        emi_pkg::OFF_PAGE:
        begin
          next_s.reg_rdata = s.page;
        end
        emi_pkg::OFF_TIMING:
        begin
          next_s.reg_rdata = s.tmg;
        end
        emi_pkg::OFF_STATUS:
        begin
          next_s.reg_rdata = {6'h00, s.offchip, s.busy};
        end
      endcase
    end

    // transfer sequencer
    unique case (s.state)
      emi_pkg::ST_IDLE:
      begin
        if (req_valid)
        begin
          next_s.write = req.write;
          next_s.wdata = req.wdata;
          next_s.addr = eff_addr;
          // mode and pin sharing are frozen for the whole move
          next_s.mux = ~s.cfg[emi_pkg::CFG_MUX_SEL];
          next_s.hi_drv = drive_hi;
          next_s.offchip = ~go_onchip;
          // aliasing keeps only the low bits, so 0x1000 hits 0x0000
          next_s.ram_addr = eff_addr[emi_pkg::RAM_AW-1:0];
          if (go_onchip)
          begin
            next_s.state = emi_pkg::ST_ONCHIP;
          end
          else
          begin
            next_s.state = emi_pkg::ST_PREP;
            next_s.cnt = emi_pkg::PREP_CYCLES - 4'h1;
          end
        end
      end
      emi_pkg::ST_ONCHIP:
      begin
        if (!s.write)
        begin
          next_s.rdata = ram[s.ram_addr];
        end
        next_s.done = 1'b1;
        next_s.state = emi_pkg::ST_IDLE;
      end
      emi_pkg::ST_PREP:
      begin
        if (s.cnt != 4'h0)
        begin
          next_s.cnt = s.cnt - 4'h1;
        end
        else if (s.mux)
        begin
          // latch width only matters on the shared pins
          next_s.state = emi_pkg::ST_ALE_HI;
          next_s.cnt = {2'b00, ale_code};
        end
        else if (setup_code != 2'h0)
        begin
          next_s.state = emi_pkg::ST_SETUP;
          next_s.cnt = {2'b00, setup_code} - 4'h1;
        end
        else
        begin
          next_s.state = emi_pkg::ST_STROBE;
          next_s.cnt = strobe_code;
        end
      end
      emi_pkg::ST_ALE_HI:
      begin
        if (s.cnt != 4'h0)
        begin
          next_s.cnt = s.cnt - 4'h1;
        end
        else
        begin
          next_s.state = emi_pkg::ST_ALE_LO;
          next_s.cnt = {2'b00, ale_code};
        end
      end
      emi_pkg::ST_ALE_LO:
      begin
        if (s.cnt != 4'h0)
        begin
          next_s.cnt = s.cnt - 4'h1;
        end
        else if (setup_code != 2'h0)
        begin
          next_s.state = emi_pkg::ST_SETUP;
          next_s.cnt = {2'b00, setup_code} - 4'h1;
        end
        else
        begin
          next_s.state = emi_pkg::ST_STROBE;
          next_s.cnt = strobe_code;
        end
      end
      emi_pkg::ST_SETUP:
      begin
        if (s.cnt != 4'h0)
        begin
          next_s.cnt = s.cnt - 4'h1;
        end
        else
        begin
          next_s.state = emi_pkg::ST_STROBE;
          next_s.cnt = strobe_code;
        end
      end
      emi_pkg::ST_STROBE:
      begin
        if (s.cnt != 4'h0)
        begin
          next_s.cnt = s.cnt - 4'h1;
        end
        else
        begin
          if (!s.write)
          begin
            // sample at the end of the strobe for the longest data setup
            next_s.rdata = ad_in;
          end
          if (hold_code != 2'h0)
          begin
            next_s.state = emi_pkg::ST_HOLD;
            next_s.cnt = {2'b00, hold_code} - 4'h1;
          end
          else
          begin
            next_s.state = emi_pkg::ST_TAIL;
            next_s.cnt = emi_pkg::TAIL_CYCLES - 4'h1;
          end
        end
      end
      emi_pkg::ST_HOLD:
      begin
        if (s.cnt != 4'h0)
        begin
          next_s.cnt = s.cnt - 4'h1;
        end
        else
        begin
          next_s.state = emi_pkg::ST_TAIL;
          next_s.cnt = emi_pkg::TAIL_CYCLES - 4'h1;
        end
      end
      emi_pkg::ST_TAIL:
      begin
        if (s.cnt != 4'h0)
        begin
          next_s.cnt = s.cnt - 4'h1;
        end
        else
        begin
          next_s.done = 1'b1;
          next_s.state = emi_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_s.state = emi_pkg::ST_IDLE;
      end
    endcase

    next_s.busy = (next_s.state != emi_pkg::ST_IDLE);

    // ****************************************
    // pins, derived from the next state so they leave a flip-flop
    // ****************************************
    in_bus = next_s.state inside {emi_pkg::ST_PREP, emi_pkg::ST_ALE_HI,
      emi_pkg::ST_ALE_LO, emi_pkg::ST_SETUP, emi_pkg::ST_STROBE, emi_pkg::ST_HOLD};
    next_s.pins.addr_hi = next_s.addr[15:8];
    next_s.pins.addr_hi_oe_n = ~(in_bus && next_s.hi_drv);
    next_s.pins.addr_lo = next_s.addr[7:0];
    // separate low address pins only without sharing
    next_s.pins.addr_lo_oe_n = ~(in_bus && !next_s.mux);
    next_s.pins.ale = (next_s.state == emi_pkg::ST_ALE_HI);
    next_s.pins.rd_n = ~((next_s.state == emi_pkg::ST_STROBE) && !next_s.write);
    next_s.pins.wr_n = ~((next_s.state == emi_pkg::ST_STROBE) && next_s.write);
    if (next_s.mux && (next_s.state inside {emi_pkg::ST_PREP, emi_pkg::ST_ALE_HI,
      emi_pkg::ST_ALE_LO}))
    begin
      // address held on the shared pins until the latch has closed
      next_s.pins.ad_out = next_s.addr[7:0];
      next_s.pins.ad_oe_n = 1'b0;
    end
    else if (next_s.write && in_bus)
    begin
      next_s.pins.ad_out = next_s.wdata;
      next_s.pins.ad_oe_n = 1'b0;
    end
    else
    begin
      next_s.pins.ad_out = 8'h00;
      next_s.pins.ad_oe_n = 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= '0;
      s.state <= emi_pkg::ST_IDLE;
      s.cfg <= emi_pkg::RST_CONFIG;
      s.page <= emi_pkg::RST_PAGE;
      s.tmg <= emi_pkg::RST_TIMING;
      s.pins.addr_hi_oe_n <= 1'b1;
      s.pins.addr_lo_oe_n <= 1'b1;
      s.pins.ad_oe_n <= 1'b1;
      s.pins.rd_n <= 1'b1;
      s.pins.wr_n <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ram has no reset; a write lands in the single on-chip cycle
  always_ff @(posedge clk)
  begin
    if ((s.state == emi_pkg::ST_ONCHIP) && s.write)
    begin
      ram[s.ram_addr] <= s.wdata;
    end
  end

  assign reg_rdata = s.reg_rdata;
  assign busy = s.busy;
  assign done = s.done;
  assign rdata = s.rdata;
  assign pins = s.pins;

endmodule : emi_ctrl

/* File: verification/emi_ctrl_sva.sv */
/*
  emi_ctrl_sva: port-level checks of emi_ctrl, bound into every instance.
  Assumes config and timing are written only while no move is in flight.
*/
`timescale 1ns/1ps
module emi_ctrl_sva (
  input logic clk,
  input logic reset,
  input logic [1:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic req_valid,
  input emi_pkg::emi_req_t req,
  input logic busy,
  input logic done,
  input logic [7:0] rdata,
  input emi_pkg::emi_pins_t pins,
  input logic [7:0] ad_in
);
  // *****
  // shadows of the config and timing registers and of the move request, and cycle counters
  // *****
  logic [7:0] cfg, tmg, wd;
  logic [5:0] acnt, scnt, bcnt, len;
  logic seen, wl, stb;
  assign stb = !pins.rd_n || !pins.wr_n;
  assign len = 6'h5 + tmg[7:6] + tmg[5:2] + tmg[1:0]
    + (cfg[4] ? 6'h0 : {cfg[1:0], 1'b0} + 6'h2);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg <= emi_pkg::RST_CONFIG;
      tmg <= emi_pkg::RST_TIMING;
      wd <= 8'h00;
      wl <= 1'b0;
      acnt <= 6'h0;
      scnt <= 6'h0;
      bcnt <= 6'h0;
      seen <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == emi_pkg::OFF_CONFIG) cfg <= reg_wdata & emi_pkg::CFG_RW_MASK;
      if (reg_wr && reg_addr == emi_pkg::OFF_TIMING) tmg <= reg_wdata;
      if (req_valid && !busy) wd <= req.wdata;
      if (req_valid && !busy) wl <= req.wide;
      acnt <= pins.ale ? acnt + 6'h1 : 6'h0;
      scnt <= stb ? scnt + 6'h1 : 6'h0;
      bcnt <= busy ? bcnt + 6'h1 : 6'h0;
      seen <= stb ? 1'b1 : (busy ? seen : 1'b0);
    end
  end
  // *****
  // assertions
  // *****
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_done_after_busy: assert property ($fell(busy) |-> done)
    else $error("done missing after busy");
  a_move_length: assert property ($fell(busy) && seen |-> bcnt == len)
    else $error("off-chip move length wrong");
  a_latch_width: assert property ($fell(pins.ale) |-> acnt == {4'h0, cfg[1:0]} + 6'h1)
    else $error("latch strobe width wrong");
  a_strobe_width: assert property ($fell(stb) |-> scnt == {2'h0, tmg[5:2]} + 6'h1)
    else $error("strobe width wrong");
  a_onchip_quick: assert property (req_valid && !busy && cfg[3:2] == 2'h0
    |=> busy ##1 done && !busy)
    else $error("on-chip move timing wrong");
  a_internal_quiet: assert property (cfg[3:2] == 2'h0 |-> pins.rd_n && pins.wr_n)
    else $error("bus strobe in internal mode");
  a_timing_read: assert property (reg_rd && reg_addr == emi_pkg::OFF_TIMING
    |=> reg_rdata == tmg)
    else $error("timing register read wrong");
  a_write_data: assert property (!pins.wr_n |-> !pins.ad_oe_n && pins.ad_out == wd)
    else $error("write data not on pins");
  a_upper_drive: assert property (stb
    |-> pins.addr_hi_oe_n == !(wl || cfg[3:2] == 2'h2))
    else $error("upper address drive wrong");
  a_mux_shared: assert property (stb && !cfg[4] |-> pins.addr_lo_oe_n)
    else $error("separate low address driven in mux");
  a_nomux_pins: assert property (cfg[4] |-> !pins.ale && (!stb || !pins.addr_lo_oe_n))
    else $error("non-mux pin use wrong");
  a_ale_addr: assert property (pins.ale |-> !pins.ad_oe_n)
    else $error("address not driven with latch strobe");
endmodule : emi_ctrl_sva

bind emi_ctrl emi_ctrl_sva u_sva (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .req_valid(req_valid), .req(req), .busy(busy), .done(done), .rdata(rdata),
  .pins(pins), .ad_in(ad_in));

/* File: verification/emi_sram_model.sv */
/*
  emi_sram_model: byte-wide asynchronous memory with an address latch.
  Assumes the pin carrier of emi_pkg; undriven upper address pins read zero.
*/
`timescale 1ns/1ps
module emi_sram_model (
  input logic clk,
  input emi_pkg::emi_pins_t pins,
  output logic [7:0] ad_in,
  output logic [15:0] last_addr,
  output int hits
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat, hi, lo;
  logic [7:0] noise = 8'h3c;
  logic stb, stb_q = 1'b0;
  assign stb = !pins.rd_n || !pins.wr_n;
  assign hi = pins.addr_hi_oe_n ? 8'h00 : pins.addr_hi;
  assign lo = pins.addr_lo_oe_n ? lat : pins.addr_lo;
  // released data pins show memory data during a read strobe, otherwise a moving pattern, never a stale value
  assign ad_in = !pins.ad_oe_n ? pins.ad_out : (!pins.rd_n ? mem[{hi, lo}] : noise);
  always_latch
  begin
    if (pins.ale) lat <= ad_in;
  end
  initial hits = 0;
  always @(posedge clk)
  begin
    noise <= noise + 8'h5b;
    stb_q <= stb;
    if (!pins.wr_n) mem[{hi, lo}] <= ad_in;
    if (stb && !stb_q)
    begin
      hits <= hits + 1;
      last_addr <= {hi, lo};
    end
  end
endmodule : emi_sram_model

/* File: verification/testbench.sv */
/*
  testbench: random and corner moves through emi_ctrl against the memory model.
  Assumes emi_pkg constants and a 20 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  logic clk, reset, reg_wr, reg_rd, req_valid, busy, done, wide;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rdata, ad_in, page, cfg, tmg, ix, wd;
  logic [15:0] last_addr, dp;
  emi_pkg::emi_req_t req;
  emi_pkg::emi_pins_t pins;
  int hits, n, h0, i, seed;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  emi_ctrl uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req(req), .busy(busy), .done(done), .rdata(rdata), .pins(pins), .ad_in(ad_in));
  emi_sram_model far (.clk(clk), .pins(pins), .ad_in(ad_in), .last_addr(last_addr),
    .hits(hits));
  // *****
  // tasks
  // *****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // internal never leaves the chip, external always does, split compares the boundary
  function automatic logic exp_offchip(input logic [15:0] a, input logic [1:0] md);
    logic above;
    above = {1'b0, a} >= emi_pkg::RAM_BYTES;
    return (md == emi_pkg::MODE_EXTERNAL) || ((md != emi_pkg::MODE_INTERNAL) && above);
  endfunction : exp_offchip
  function automatic int exp_len(input logic oc, input logic [7:0] c, input logic [7:0] t);
    int latch;
    latch = c[4] ? 0 : 2 * (c[1:0] + 1);
    return oc ? 4 + t[7:6] + t[5:2] + 1 + t[1:0] + latch : 1;
  endfunction : exp_len
  // released upper pins read as zero in the memory model
  function automatic logic [15:0] exp_addr(input logic [15:0] a, input logic w16,
    input logic [1:0] md);
    logic drive;
    drive = w16 || (md == emi_pkg::MODE_SPLIT_BANK);
    return {drive ? a[15:8] : 8'h00, a[7:0]};
  endfunction : exp_addr
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check("reg", {8'h00, reg_rdata}, {8'h00, exp});
  endtask : reg_read
  task automatic move(input logic w, input logic [15:0] p, input logic [7:0] x,
    input logic [7:0] d);
    logic [15:0] a;
    logic oc;
    a = wide ? p : {page, x};
    oc = exp_offchip(a, cfg[3:2]);
    h0 = hits;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{w, wide, p, x, d};
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    repeat (60)
    begin
      @(negedge clk);
      if (busy === 1'b1) n++;
      if (done === 1'b1) break;
    end
    check("len", 16'(n), 16'(exp_len(oc, cfg, tmg)));
    check("bus", 16'(hits - h0), {15'h0, oc});
    if (oc) check("addr", last_addr, exp_addr(a, wide, cfg[3:2]));
    if (!w) check("rdata", {8'h00, rdata}, {8'h00, d});
  endtask : move
  // *****
  // stimulus
  // *****
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 30000)
    begin
      n_errors++;
      test_done;
    end
  end
  initial
  begin
    seed = 32'hebf8;
    {reset, reg_wr, reg_rd, req_valid, reg_addr, reg_wdata, req} = '0;
    reset = 1'b1;
    tmg = emi_pkg::RST_TIMING;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    reg_read(emi_pkg::OFF_CONFIG, emi_pkg::RST_CONFIG);
    reg_read(emi_pkg::OFF_TIMING, emi_pkg::RST_TIMING);
    reg_read(emi_pkg::OFF_PAGE, emi_pkg::RST_PAGE);
    reg_write(emi_pkg::OFF_STATUS, 8'hff);
    reg_read(emi_pkg::OFF_STATUS, 8'h00);
    for (i = 0; i < 48; i++)
    begin
      // first sixteen: every mode, both pin setups, boundary addresses, max timing
      cfg = (i < 16) ? {3'h0, i[0], i[2:1], 2'h3} : 8'($random(seed));
      if (i >= 16) tmg = 8'($random(seed));
      page = (i < 16) ? 8'h0f + 8'(i[0]) : 8'($random(seed));
      dp = (i < 16) ? 16'h0fff + 16'(i[0]) : 16'($random(seed));
      wide = (i < 16) ? i[3] : 1'($random(seed));
      ix = 8'($random(seed));
      wd = 8'($random(seed));
      reg_write(emi_pkg::OFF_CONFIG, cfg);
      cfg = cfg & emi_pkg::CFG_RW_MASK;
      reg_write(emi_pkg::OFF_TIMING, tmg);
      reg_write(emi_pkg::OFF_PAGE, page);
      reg_read(emi_pkg::OFF_CONFIG, cfg);
      reg_read(emi_pkg::OFF_TIMING, tmg);
      reg_read(emi_pkg::OFF_PAGE, page);
      move(1'b1, dp, ix, wd);
      move(1'b0, (cfg[3:2] == 2'h0) ? dp + 16'h1000 : dp, ix, wd);
    end
    test_done;
  end
endmodule : testbench
